// ---- rtl/dac_cfg_pkg.sv ----
// Constants and types for the DAC sync, FIFO and alarm configuration bank.
// Assumes one 20 MHz clock and a decoded register port from the serial interface.
`default_nettype none

package dac_cfg_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] SYNC_LAT_OFS  = 8'h02;
  localparam logic [7:0] FIFO_ALM_OFS  = 8'h03;
  localparam logic [7:0] CUR_SCALE_OFS = 8'h04;
  localparam logic [7:0] DIE_TEMP_OFS  = 8'h05;
  localparam logic [7:0] ALM_MASK_OFS  = 8'h06;
  localparam logic [7:0] ALM_FLAG_OFS  = 8'h07;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SYNC_LAT_RST  = 8'h00;
  localparam logic [7:0] FIFO_ALM_RST  = 8'h10;
  localparam logic [7:0] CUR_SCALE_RST = 8'hFF;
  localparam logic [7:0] ALM_MASK_RST  = 8'h00;
  localparam logic [7:0] ALM_FLAG_RST  = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int SW_SYNC_BIT     = 5;
  localparam int SW_SYNC_SEL_BIT = 4;
  localparam int LAT_LSB         = 0;
  localparam int LAT_W           = 2;
  localparam int AUTO_CLR_BIT    = 7;
  localparam int PRELOAD_LSB     = 2;
  localparam int PRELOAD_W       = 3;
  localparam int NEAR2_EN_BIT    = 1;
  localparam int NEAR1_EN_BIT    = 0;
  localparam int SCALE_A_LSB     = 4;
  localparam int SCALE_B_LSB     = 0;
  localparam int SCALE_W         = 4;
  localparam int ALM_W           = 7;

  // Alarm flag bit positions
  localparam int STUCK_BIT    = 6;
  localparam int OVERRUN_BIT  = 5;
  localparam int MISMATCH_BIT = 3;
  localparam int NEAR2_BIT    = 1;
  localparam int NEAR1_BIT    = 0;
  localparam logic [6:0] ALM_USED = 7'h6B;

  // ==========================================================================
  // Timing and data
  localparam logic [6:0] GOOD_RUN = 7'h40;
  localparam int         MAX_LAT  = 3;
  localparam int         SAMPLE_W = 16;

  typedef struct packed {
    logic [SAMPLE_W-1:0] chan_a;
    logic [SAMPLE_W-1:0] chan_b;
  } dac_pair_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

`default_nettype wire

// ---- rtl/dac_latency_line.sv ----
// Programmable delay line for the converter sample pair.
// Assumes the latency code is stable while data flows; output is registered.
`default_nettype none

module dac_latency_line
  import dac_cfg_pkg::*;
(
  input  wire logic            sys_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic [LAT_W-1:0] latency_i,
  input  wire dac_pair_t       data_i,
  output var  dac_pair_t       data_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    dac_pair_t [MAX_LAT-1:0] taps;
    dac_pair_t               out;
  } line_state_t;

  line_state_t st_reg;
  line_state_t st_next;

  always_comb begin
    st_next          = st_reg;
    st_next.taps[0]  = data_i;
    for (int i = 1; i < MAX_LAT; i++) begin
      st_next.taps[i] = st_reg.taps[i-1];
    end
    // Code zero bypasses the taps; one fixed output stage is always present
    if (latency_i == '0) begin
      st_next.out = data_i;
    end else begin
      st_next.out = st_reg.taps[latency_i - 2'd1];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_o = st_reg.out;

endmodule

`default_nettype wire

// ---- rtl/dac_sync_fifo_alarm_config.sv ----
// Sync, latency, FIFO alarm and output scale register bank of a dual DAC.
// Assumes a decoded register port from the serial interface, one clock.
// Alarm events, the polarity select and the sensor reading come from outside.
//
// Overview of operation
// - Software sync bit holds sync until cleared.
// - Select bit picks software sync, ignores strobe.
// - Latency field delays both channels one-four cycles.
// - Auto clear flags after 64 good samples.
// - FIFO reset loads read pointer preload value.
// - Two-away alarm reported only when enabled.
// - One-away alarm reported only when enabled.
// - Channel A current scale, sixteen steps.
// - Channel B current scale, sixteen steps.
// - Temperature register returns signed sensor reading.
// - Masked alarm never drives the alarm pin.
// - Masked alarm still recorded in flag register.
// - Mask bits active high, fixed alarm mapping.
// - Polarity select sets alarm pin active level.
// - Flags reset zero, host write clears them.
`default_nettype none

module dac_sync_fifo_alarm_config
  import dac_cfg_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // Decoded register access
  input  wire reg_req_t             reg_req_i,
  output var  logic [7:0]           reg_rdata_o,
  output var  logic                 reg_rvalid_o,
  // Sync
  input  wire logic                 fifo_input_strobe_i,
  output var  logic                 sync_o,
  // FIFO
  input  wire logic                 fifo_reset_i,
  output var  logic                 rd_ptr_load_o,
  output var  logic [PRELOAD_W-1:0] rd_ptr_preload_o,
  // Alarm sources, one-cycle pulses
  input  wire logic [ALM_W-1:0]     alarm_event_i,
  input  wire logic                 good_sample_i,
  input  wire logic                 alarm_polarity_sel_i,
  output var  logic                 alarm_serial_out_pin_o,
  // Converters
  input  wire logic [7:0]           die_temp_sensor_i,
  input  wire dac_pair_t            sample_i,
  output var  dac_pair_t            sample_o,
  output var  logic [SCALE_W-1:0]   chan_a_current_scale_o,
  output var  logic [SCALE_W-1:0]   chan_b_current_scale_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]           sync_lat;
    logic [7:0]           fifo_alm;
    logic [7:0]           cur_scale;
    logic [7:0]           alm_mask;
    logic [ALM_W-1:0]     flags;
    logic [6:0]           good_cnt;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 sync;
    logic                 ptr_load;
    logic [PRELOAD_W-1:0] preload;
    logic                 pin;
  } bank_state_t;

  bank_state_t st_reg;
  bank_state_t st_next;

  logic [ALM_W-1:0]     alm_en;
  logic [ALM_W-1:0]     alm_set;
  logic [ALM_W-1:0]     alm_clr;
  logic [ALM_W-1:0]     alm_unmasked;
  logic                 pin_active;
  logic                 sw_sync;
  logic                 sw_sync_sel;
  logic                 auto_clr_en;
  logic                 near2_en;
  logic                 near1_en;
  logic                 run_done;
  logic [LAT_W-1:0]     latency;
  logic [PRELOAD_W-1:0] preload_val;
  logic [7:0]           rd_mux;

  // ==========================================================================
  // Field views of the control registers
  // Sync and latency register
  assign sw_sync     = st_reg.sync_lat[SW_SYNC_BIT];
  assign sw_sync_sel = st_reg.sync_lat[SW_SYNC_SEL_BIT];
  assign latency     = st_reg.sync_lat[LAT_LSB +: LAT_W];
  // FIFO and alarm register
  assign auto_clr_en = st_reg.fifo_alm[AUTO_CLR_BIT];
  assign preload_val = st_reg.fifo_alm[PRELOAD_LSB +: PRELOAD_W];
  assign near2_en    = st_reg.fifo_alm[NEAR2_EN_BIT];
  assign near1_en    = st_reg.fifo_alm[NEAR1_EN_BIT];
  // Counter parks at the run length while auto clear is off, so arming it clears at once
  assign run_done    = auto_clr_en && (st_reg.good_cnt == GOOD_RUN);

  // ==========================================================================
  // Read mux; the temperature is taken live at the read edge
  always_comb begin
    case (reg_req_i.addr)
      SYNC_LAT_OFS:  rd_mux = st_reg.sync_lat;
      FIFO_ALM_OFS:  rd_mux = st_reg.fifo_alm;
      CUR_SCALE_OFS: rd_mux = st_reg.cur_scale;
      DIE_TEMP_OFS:  rd_mux = die_temp_sensor_i;
      ALM_MASK_OFS:  rd_mux = st_reg.alm_mask;
      ALM_FLAG_OFS:  rd_mux = {1'b0, st_reg.flags};
      // Unmapped addresses read as zero; there is no error response
      default:       rd_mux = 8'h00;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;

    // Near-pointer alarms are gated before latching, so disabled ones never appear
    alm_en               = ALM_USED;
    alm_en[NEAR2_BIT]    = near2_en;
    alm_en[NEAR1_BIT]    = near1_en;
    alm_set              = alarm_event_i & alm_en;
    alm_clr              = '0;

    // Register writes
    // Writes to the read-only temperature offset fall to the default and are lost
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        SYNC_LAT_OFS:  st_next.sync_lat  = reg_req_i.wdata;
        FIFO_ALM_OFS:  st_next.fifo_alm  = reg_req_i.wdata;
        CUR_SCALE_OFS: st_next.cur_scale = reg_req_i.wdata;
        ALM_MASK_OFS:  st_next.alm_mask  = reg_req_i.wdata;
        ALM_FLAG_OFS:  alm_clr           = reg_req_i.wdata[ALM_W-1:0];
        default:       st_next.sync_lat  = st_reg.sync_lat;
      endcase
    end

    // Good-sample run; any new latched alarm restarts it
    if (alm_set != '0) begin
      st_next.good_cnt = '0;
    end else if (good_sample_i && st_reg.good_cnt != GOOD_RUN) begin
      st_next.good_cnt = st_reg.good_cnt + 7'h01;
    end
    if (run_done) begin
      alm_clr          = '1;
      st_next.good_cnt = '0;
    end

    // Set wins over clear; masked alarms are still recorded
    // Bits 4 and 2 have no source and always read zero
    st_next.flags = ((st_reg.flags & ~alm_clr) | alm_set) & ALM_USED;

    // Reads
    st_next.rvalid = reg_req_i.rd;
    if (reg_req_i.rd) begin
      st_next.rdata = rd_mux;
    end

    // Software sync replaces the strobe entirely when selected
    if (sw_sync_sel) begin
      st_next.sync = sw_sync;
    end else begin
      st_next.sync = fifo_input_strobe_i;
    end

    // Preload captured at the reset pulse, so later writes leave it alone
    st_next.ptr_load = fifo_reset_i;
    if (fifo_reset_i) begin
      st_next.preload = preload_val;
    end

    // Pin is built from the next flags and mask, so it moves on the same edge as the flags
    alm_unmasked = st_next.flags & ~st_next.alm_mask[ALM_W-1:0];
    pin_active   = |alm_unmasked;
    // Polarity is a live input, so flipping it moves the pin on the next edge
    st_next.pin  = alarm_polarity_sel_i ? pin_active : ~pin_active;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg           <= '0;
      st_reg.sync_lat  <= SYNC_LAT_RST;
      st_reg.fifo_alm  <= FIFO_ALM_RST;
      st_reg.cur_scale <= CUR_SCALE_RST;
      st_reg.alm_mask  <= ALM_MASK_RST;
      st_reg.flags     <= ALM_FLAG_RST[ALM_W-1:0];
      // Idle pin level of the active-low default
      st_reg.pin       <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Output delay
  // A latency change while samples flow repeats or skips up to three of them
  dac_latency_line u_latency (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .latency_i (latency),
    .data_i    (sample_i),
    .data_o    (sample_o)
  );

  assign reg_rdata_o            = st_reg.rdata;
  assign reg_rvalid_o           = st_reg.rvalid;
  assign sync_o                 = st_reg.sync;
  assign rd_ptr_load_o          = st_reg.ptr_load;
  assign rd_ptr_preload_o       = st_reg.preload;
  assign alarm_serial_out_pin_o = st_reg.pin;
  assign chan_a_current_scale_o = st_reg.cur_scale[SCALE_A_LSB +: SCALE_W];
  assign chan_b_current_scale_o = st_reg.cur_scale[SCALE_B_LSB +: SCALE_W];

endmodule

`default_nettype wire

// ---- bench/dac_cfg_checker.sv ----
// Port checker for the DAC sync, FIFO and alarm bank.
// Assumes a bind onto the bank; one clock, async active-low reset.
`default_nettype none

module dac_cfg_checker
  import dac_cfg_pkg::*;
(
  input wire logic               sys_clk_i,
  input wire logic               rst_n_i,
  input wire reg_req_t           reg_req_i,
  input wire logic [7:0]         reg_rdata_o,
  input wire logic               reg_rvalid_o,
  input wire logic [7:0]         die_temp_sensor_i,
  input wire logic               fifo_reset_i,
  input wire logic               rd_ptr_load_o,
  input wire logic               sync_o,
  input wire logic [SCALE_W-1:0] chan_a_current_scale_o,
  input wire logic [SCALE_W-1:0] chan_b_current_scale_o
);
  // ==========================================================================
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic wr_sc;
  logic wr_sy;
  assign wr_sc = reg_req_i.wr && reg_req_i.addr == CUR_SCALE_OFS;
  assign wr_sy = reg_req_i.wr && reg_req_i.addr == SYNC_LAT_OFS;

  chk_temp_read: assert property (
    reg_req_i.rd && reg_req_i.addr == DIE_TEMP_OFS
    |=> reg_rvalid_o && reg_rdata_o == $past(die_temp_sensor_i)) else $error("temp read");
  chk_flag_unused: assert property (
    reg_req_i.rd && reg_req_i.addr == ALM_FLAG_OFS
    |=> reg_rvalid_o && (reg_rdata_o & 8'h94) == 8'h00) else $error("unused flag bit");
  chk_load_pulse: assert property (fifo_reset_i |=> rd_ptr_load_o)
    else $error("no pointer load");
  chk_load_cause: assert property (rd_ptr_load_o |-> $past(fifo_reset_i))
    else $error("stray pointer load");
  chk_scale_a: assert property (
    wr_sc |=> chan_a_current_scale_o == $past(reg_req_i.wdata[7:4])) else $error("scale a");
  chk_scale_b: assert property (
    wr_sc |=> chan_b_current_scale_o == $past(reg_req_i.wdata[3:0])) else $error("scale b");
  chk_scale_hold: assert property (
    !wr_sc |=> $stable({chan_a_current_scale_o, chan_b_current_scale_o}))
    else $error("scale moved");
  chk_sw_sync: assert property (
    wr_sy && reg_req_i.wdata[4] ##1 !wr_sy |=> sync_o == $past(reg_req_i.wdata[5], 2))
    else $error("software sync");

  cov_fifo_reset: cover property (fifo_reset_i);
  cov_flag_read: cover property (reg_req_i.rd && reg_req_i.addr == ALM_FLAG_OFS);
  cov_sync: cover property ($rose(sync_o));
endmodule

bind dac_sync_fifo_alarm_config dac_cfg_checker u_chk (
  .sys_clk_i, .rst_n_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o, .die_temp_sensor_i,
  .fifo_reset_i, .rd_ptr_load_o, .sync_o, .chan_a_current_scale_o, .chan_b_current_scale_o
);

`default_nettype wire

// ---- bench/dac_host_model.sv ----
// Host controller model for the decoded register port.
// Assumes callers enter req just after a rising edge.
`default_nettype none

module dac_host_model
  import dac_cfg_pkg::*;
(
  input  wire logic     sys_clk_i,
  output var  reg_req_t reg_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial reg_req_o = '0;
  // ==========================================================================
  // One access, then an idle cycle with a scrambled address and data;
  // entered and left 1 ns after a rising edge, so outputs are read settled
  task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
    // Temperature reads kept 1 us apart
    if (!w && a == DIE_TEMP_OFS) begin
      repeat (20) @(posedge sys_clk_i);
      #1;
    end
    reg_req_o = '{w, !w, a, d};
    @(posedge sys_clk_i);
    #1 reg_req_o = '{1'b0, 1'b0, ~a, 8'($urandom)};
    @(posedge sys_clk_i);
    #1;
  endtask
endmodule

`default_nettype wire

// ---- bench/test_dac_sync_fifo_alarm_config.sv ----
// Self-checking bench for the DAC sync, FIFO and alarm bank.
// Assumes the host model owns the register port; one 20 MHz clock.
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module test_dac_sync_fifo_alarm_config
  import dac_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk_i = 0, rst_n_i = 0, strobe = 0, fifo_rst = 0, good = 0, pol = 1;
  logic [6:0] evt = '0;
  logic [7:0] temp = '0, rdata, exp_rd, expq[$];
  logic [3:0] sa, sb;
  logic [2:0] pre;
  logic       rvalid, sync, load, pin;
  dac_pair_t  smp = '0, smp_o;
  reg_req_t   req;
  int         failures = 0, checks = 0, cyc = 0;
  int         bits[5] = '{6, 5, 3, 1, 0};
  always #25 sys_clk_i = ~sys_clk_i;

  dac_host_model u_host (.sys_clk_i(sys_clk_i), .reg_req_o(req));
  dac_sync_fifo_alarm_config u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .fifo_input_strobe_i(strobe), .sync_o(sync),
    .fifo_reset_i(fifo_rst), .rd_ptr_load_o(load), .rd_ptr_preload_o(pre),
    .alarm_event_i(evt), .good_sample_i(good), .alarm_polarity_sel_i(pol),
    .alarm_serial_out_pin_o(pin), .die_temp_sensor_i(temp), .sample_i(smp),
    .sample_o(smp_o), .chan_a_current_scale_o(sa), .chan_b_current_scale_o(sb));

  // ==========================================================================
  // Helpers and read-data scoreboard
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.req(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    u_host.req(1'b0, a, 8'h00);
  endtask
  task automatic pulse(input int b);
    evt[b] = 1'b1;
    tick(1);
    evt = '0;
    tick(1);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Pop once into a variable; the macro names its expected value twice
  always @(negedge sys_clk_i) if (rvalid === 1'b1) begin
    exp_rd = expq.pop_front();
    `CHK(rdata, exp_rd)
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [2:0] p;
    dac_pair_t  v;
    void'($urandom(32'hD0458BEC));
    temp = 8'($urandom);
    repeat (20) @(posedge sys_clk_i);
    #1 rst_n_i = 1;
    `CHK({sa, sb}, 8'hFF)
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h10);
    rd(8'h04, 8'hFF);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    wr(DIE_TEMP_OFS, ~temp);
    rd(DIE_TEMP_OFS, temp);
    rd(8'h00, 8'h00);
    d = 8'($urandom);
    wr(CUR_SCALE_OFS, d);
    `CHK({sa, sb}, d)
    $display("done registers");
    strobe = 1;
    tick(2);
    `CHK(sync, 1'b1)
    wr(SYNC_LAT_OFS, 8'h10);
    tick(1);
    `CHK(sync, 1'b0)
    wr(SYNC_LAT_OFS, 8'h30);
    strobe = 0;
    tick(6);
    `CHK(sync, 1'b1)
    wr(SYNC_LAT_OFS, 8'h10);
    tick(1);
    `CHK(sync, 1'b0)
    $display("done sync");
    for (int l = 0; l < 4; l++) begin
      wr(SYNC_LAT_OFS, 8'(l));
      v = dac_pair_t'($urandom);
      smp = v;
      tick(1);
      smp = '0;
      tick(l);
      `CHK(smp_o, v)
    end
    fifo_rst = 1;
    tick(1);
    fifo_rst = 0;
    `CHK({load, pre}, 4'hC)
    p = 3'($urandom);
    wr(FIFO_ALM_OFS, {3'b000, p, 2'b00});
    fifo_rst = 1;
    tick(1);
    fifo_rst = 0;
    `CHK({load, pre}, {1'b1, p})
    $display("done latency fifo");
    pulse(1);
    pulse(0);
    pulse(4);
    pulse(2);
    `CHK(pin, 1'b0)
    rd(ALM_FLAG_OFS, 8'h00);
    wr(FIFO_ALM_OFS, 8'h13);
    for (int i = 0; i < 5; i++) begin
      wr(ALM_MASK_OFS, 8'(1 << bits[i]));
      pulse(bits[i]);
      `CHK(pin, 1'b0)
      rd(ALM_FLAG_OFS, 8'(1 << bits[i]));
      wr(ALM_MASK_OFS, 8'h00);
      tick(1);
      `CHK(pin, 1'b1)
      wr(ALM_FLAG_OFS, 8'(1 << bits[i]));
      tick(1);
      `CHK(pin, 1'b0)
    end
    pol = 0;
    pulse(5);
    `CHK(pin, 1'b0)
    wr(ALM_FLAG_OFS, 8'h20);
    tick(1);
    `CHK(pin, 1'b1)
    pol = 1;
    wr(FIFO_ALM_OFS, 8'h90);
    pulse(3);
    good = 1;
    tick(63);
    good = 0;
    rd(ALM_FLAG_OFS, 8'h08);
    good = 1;
    tick(1);
    good = 0;
    tick(1);
    rd(ALM_FLAG_OFS, 8'h00);
    $display("done alarms");
    tick(4);
    finish_test();
  end
endmodule

`default_nettype wire
